// file: hw/tis_i2s_master.sv
// Telephony I2S master port: bit clock, word select, speaker out, microphone in.
// Assumes clk at 20 MHz for the user side and link_clk as the bit clock source.
`timescale 1ns/1ps
`default_nettype none

module tis_i2s_master
  import tis_pkg::*;
#(
  parameter int unsigned LINK_HZ = LINK_CLK_HZ,
  parameter int unsigned BCLK_RATE_HZ = BCLK_HZ
) (
  input  wire logic  clk,
  input  wire logic  srst,
  input  wire logic  audio_enable,
  input  wire tis_spk_t spk_in,
  output var  logic  spk_ready,
  output var  tis_mic_t mic_out,
  output var  logic  sleep_allowed,
  input  wire logic  link_clk,
  input  wire logic  mic_serial_in,
  output var  tis_pins_t i2s_pins
);

  // Half period of the bit clock in link clocks; rounding down keeps the rate
  // at or just above 512 kHz while the duty cycle stays at exactly one half.
  localparam int unsigned HALF_CNT_I = (LINK_HZ / (2 * BCLK_RATE_HZ)) < 1 ? 1 :
                                       (LINK_HZ / (2 * BCLK_RATE_HZ));
  localparam int unsigned DIV_W      = $clog2(HALF_CNT_I + 1);
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CNT_I - 1);

  // The frame geometry must tie the bit clock to the sample rate
  localparam int unsigned FRAME_HZ = BCLK_RATE_HZ / FRAME_BITS;

  //--------------------------------------------------------------------------
  // System clock domain declarations
  //--------------------------------------------------------------------------
  tis_sample_t spk_hold_r;
  logic        spk_tog_r;
  logic        spk_ack_sync;
  logic        mic_tog_sync;
  logic        mic_tog_seen_r;
  logic        run_sync;
  logic        spk_busy;

  //--------------------------------------------------------------------------
  // Link clock domain declarations
  //--------------------------------------------------------------------------
  logic            link_rst;
  logic            en_link;
  logic            spk_tog_link;
  logic            spk_tog_seen_r;
  logic            din_sync;
  tis_link_state_t lstate_r;
  logic            running;
  logic [DIV_W-1:0] half_cnt_r;
  logic            half_done;
  logic            bclk_r;
  logic            rise_ev;
  logic            fall_ev;
  logic            stop_ev;
  logic [4:0]      bit_idx_r;
  logic [4:0]      bit_idx_nxt;
  logic            ws_r;
  logic            dout_r;
  logic [FRAME_BITS-1:0] tx_sh_r;
  tis_sample_t     spk_word_r;
  tis_sample_t     rx_sh_r;
  tis_sample_t     mic_word_r;
  logic            mic_tog_r;

  //==========================================================================
  // Crossings
  //==========================================================================

  // Reset into the link domain; neither of its stages is ever reset, so the
  // release reaches the link logic two link clocks after srst falls.
  tis_sync2 #(
    .WIDTH (1)
  ) u_rst_sync (
    .clk  (link_clk),
    .srst (1'b0),
    .d    (srst),
    .q    (link_rst)
  );

  // Enable level, speaker toggle and the codec data pin into the link domain
  tis_sync2 #(
    .WIDTH (3)
  ) u_to_link (
    .clk  (link_clk),
    .srst (link_rst),
    .d    ({audio_enable, spk_tog_r, mic_serial_in}),
    .q    ({en_link, spk_tog_link, din_sync})
  );

  // Run status, speaker acknowledge and microphone toggle into the system domain
  tis_sync2 #(
    .WIDTH (3)
  ) u_to_sys (
    .clk  (clk),
    .srst (srst),
    .d    ({running, spk_tog_seen_r, mic_tog_r}),
    .q    ({run_sync, spk_ack_sync, mic_tog_sync})
  );

  //==========================================================================
  // System clock domain
  //==========================================================================

  // A speaker sample is in flight until the link side echoes its toggle
  assign spk_busy  = spk_tog_r != spk_ack_sync;
  assign spk_ready = !spk_busy;

  // Hold the offered sample stable while the link side copies it
  always_ff @(posedge clk) begin
    if (srst) begin
      spk_hold_r <= SAMPLE_RST;
      spk_tog_r  <= 1'b0;
    end else if (spk_in.valid && !spk_busy) begin
      spk_hold_r <= spk_in.sample;
      spk_tog_r  <= !spk_tog_r;
    end
  end

  // New left sample: the link word is stable for a whole frame after its toggle
  always_ff @(posedge clk) begin
    if (srst) begin
      mic_tog_seen_r <= 1'b0;
      mic_out        <= '0;
    end else begin
      mic_tog_seen_r <= mic_tog_sync;
      mic_out.valid  <= mic_tog_sync != mic_tog_seen_r;
      if (mic_tog_sync != mic_tog_seen_r) begin
        mic_out.sample <= mic_word_r;
      end
    end
  end

  // Sleep is only safe once the bit clock has really stopped
  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_allowed <= 1'b0;
    end else begin
      sleep_allowed <= !run_sync;
    end
  end

  //==========================================================================
  // Link clock domain
  //==========================================================================

  assign running   = lstate_r == LS_RUN;
  assign half_done = half_cnt_r == HALF_LAST;
  assign rise_ev   = running && half_done && !bclk_r;
  assign fall_ev   = running && half_done && bclk_r;
  assign stop_ev   = fall_ev && bit_idx_nxt == 5'h00 && !en_link;

  // Index of the bit that the next falling edge opens
  assign bit_idx_nxt = bit_idx_r + 5'h01;

  // Start on enable; stop only at a frame boundary, on the fall that would send
  // the last right-slot bit, so the codec never clocks that bit in. The stop edge is a falling one, so the clock parks low.
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lstate_r <= LS_IDLE;
    end else begin
      unique case (lstate_r)
        LS_IDLE: begin
          if (en_link) begin
            lstate_r <= LS_RUN;
          end
        end
        LS_RUN: begin
          if (stop_ev) begin
            lstate_r <= LS_IDLE;
          end
        end
      endcase
    end
  end

  // Bit clock divider; equal half periods hold the duty cycle at 50 percent
  always_ff @(posedge link_clk) begin
    if (link_rst || !running) begin
      half_cnt_r <= '0;
    end else if (half_done) begin
      half_cnt_r <= '0;
    end else begin
      half_cnt_r <= half_cnt_r + DIV_W'(1);
    end
  end

  // Bit clock output, low whenever the port is idle
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      bclk_r <= PIN_RST;
    end else if (!running) begin
      bclk_r <= PIN_RST;
    end else if (half_done) begin
      bclk_r <= !bclk_r;
    end
  end

  // Frame bit counter: 32 bit clocks per frame gives the 16 kHz frame rate
  always_ff @(posedge link_clk) begin
    if (link_rst || !running) begin
      bit_idx_r <= IDLE_BIT_IDX;
    end else if (fall_ev) begin
      bit_idx_r <= bit_idx_nxt;
    end
  end

  // Word select: low for bits 0 to 15, high for bits 16 to 31
  always_ff @(posedge link_clk) begin
    if (link_rst || !running) begin
      ws_r <= PIN_RST;
    end else if (fall_ev) begin
      ws_r <= bit_idx_nxt >= WS_HIGH_BIT;
    end
  end

  // Take a new speaker sample; it is used from the next frame start on
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      spk_tog_seen_r <= 1'b0;
      spk_word_r     <= SAMPLE_RST;
    end else if (spk_tog_link != spk_tog_seen_r) begin
      spk_tog_seen_r <= spk_tog_link;
      spk_word_r     <= spk_hold_r;
    end
  end

  // Transmit shifter. At each frame start the same word is loaded into both
  // halves while the last right-slot bit still goes out, which puts every
  // MSB one bit clock behind its word select edge.
  always_ff @(posedge link_clk) begin
    if (link_rst || !running) begin
      tx_sh_r <= '0;
      dout_r  <= PIN_RST;
    end else if (fall_ev) begin
      // Park the data line on the stopping fall itself, never between edges
      dout_r <= stop_ev ? PIN_RST : tx_sh_r[FRAME_BITS-1];
      if (bit_idx_nxt == 5'h00) begin
        tx_sh_r <= {spk_word_r, spk_word_r};
      end else begin
        tx_sh_r <= {tx_sh_r[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // Receive shifter: sample on rising edges of bits 1 to 16 only, so the
  // right slot never reaches the user side.
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rx_sh_r <= SAMPLE_RST;
    end else if (rise_ev && bit_idx_r >= FIRST_DATA_BIT && bit_idx_r <= LEFT_LAST_BIT) begin
      rx_sh_r <= {rx_sh_r[WORD_BITS-2:0], din_sync};
    end
  end

  // Publish the left word after its LSB; it stays put for a whole frame,
  // long enough for the toggle to cross before the word can change.
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      mic_word_r <= SAMPLE_RST;
      mic_tog_r  <= 1'b0;
    end else if (rise_ev && bit_idx_r == LEFT_LAST_BIT) begin
      mic_word_r <= {rx_sh_r[WORD_BITS-2:0], din_sync};
      mic_tog_r  <= !mic_tog_r;
    end
  end

  // Pins toward the codec, all from flip-flops in the link domain
  assign i2s_pins.audio_bit_clock   = bclk_r;
  assign i2s_pins.frame_word_select = ws_r;
  assign i2s_pins.spk_serial_out    = dout_r;

endmodule

`default_nettype wire

// file: shared/tis_pkg.sv
// Shared constants and carrier types for the telephony I2S master port.
// Assumes a system clock of 20 MHz and a separate link clock feeding the bit clock divider.
package tis_pkg;

  // Audio frame geometry
  localparam int unsigned SAMPLE_RATE_HZ = 16000;
  localparam int unsigned BCLK_HZ        = 512000;
  localparam int unsigned FRAME_BITS     = 32;
  localparam int unsigned WORD_BITS      = 16;

  // System clock rate and default link clock rate (15 ns period)
  localparam int unsigned SYS_CLK_HZ     = 20000000;
  localparam int unsigned LINK_CLK_HZ    = 66666667;

  // Frame bit index width and position where the word select rises
  localparam int unsigned BIT_IDX_W      = 5;
  localparam logic [4:0]  WS_HIGH_BIT    = 5'h10;
  localparam logic [4:0]  FIRST_DATA_BIT = 5'h01;
  localparam logic [4:0]  LEFT_LAST_BIT  = 5'h10;
  localparam logic [4:0]  IDLE_BIT_IDX   = 5'h1f;

  // Reset values of the pins and samples
  localparam logic [15:0] SAMPLE_RST     = 16'h0000;
  localparam logic        PIN_RST        = 1'b0;

  typedef logic [WORD_BITS-1:0] tis_sample_t;

  // Outgoing pins toward the codec
  typedef struct packed {
    logic audio_bit_clock;
    logic frame_word_select;
    logic spk_serial_out;
  } tis_pins_t;

  // Received microphone sample, valid for one system clock
  typedef struct packed {
    logic        valid;
    tis_sample_t sample;
  } tis_mic_t;

  // Loudspeaker sample offered by the user side
  typedef struct packed {
    logic        valid;
    tis_sample_t sample;
  } tis_spk_t;

  // Link side sequencer states
  typedef enum logic [0:0] {
    LS_IDLE,
    LS_RUN
  } tis_link_state_t;

endpackage

// file: hw/tis_sync2.sv
// Two flip-flop synchroniser for levels and toggles, any width.
// Assumes each bit is a level or a toggle that stays put for several destination clocks.
`timescale 1ns/1ps
`default_nettype none

module tis_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

`default_nettype wire

// file: test/tis_i2s_properties.sv
// Checker for the I2S master pins and user side.
// Assumes LINK_HZ set for four link clocks per bit clock half.
`timescale 1ns/1ps
`default_nettype none
module tis_i2s_properties
  import tis_pkg::*;
#(
  parameter int unsigned LINK_HZ      = LINK_CLK_HZ,
  parameter int unsigned BCLK_RATE_HZ = BCLK_HZ
) (
  input wire logic      clk,
  input wire logic      srst,
  input wire logic      audio_enable,
  input wire tis_spk_t  spk_in,
  input wire logic      spk_ready,
  input wire tis_mic_t  mic_out,
  input wire logic      sleep_allowed,
  input wire logic      link_clk,
  input wire logic      mic_serial_in,
  input wire tis_pins_t i2s_pins
);
  logic        bck;
  logic        ws;
  logic        dq;
  logic        bck_r;
  logic [4:0]  bit_r;
  logic [15:0] hist_r;
  logic [1:0]  lrst_r;
  logic        link_srst;
  // Reset as the port's link logic sees it, two link clocks late
  always_ff @(posedge link_clk) begin
    lrst_r <= {lrst_r[0], srst};
  end
  assign link_srst = srst || lrst_r[1];
  assign bck = i2s_pins.audio_bit_clock;
  assign ws  = i2s_pins.frame_word_select;
  assign dq  = i2s_pins.spk_serial_out;
  // Edge history of the bit clock
  always_ff @(posedge link_clk) begin
    bck_r <= bck;
  end
  // Bit index; only whole frames are run, so falls modulo 32 track it
  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      bit_r <= 5'h1f;
    end else if (bck_r && !bck) begin
      bit_r <= bit_r + 5'h01;
    end
  end
  // Data seen at each rise, kept sixteen bits deep for the slot copy
  always_ff @(posedge link_clk) begin
    if (link_srst) begin
      hist_r <= 16'h0000;
    end else if (bck && !bck_r) begin
      hist_r <= {hist_r[14:0], dq};
    end
  end
  sequence s_high;
    bck [*4];
  endsequence
  sequence s_low;
    !bck [*4];
  endsequence
  a_bclk_duty: assert property (@(posedge link_clk) disable iff (link_srst)
    $rose(bck) |-> s_high ##1 s_low) else $error("bit clock half period wrong");
  a_ws_on_fall: assert property (@(posedge link_clk) disable iff (link_srst)
    $changed(ws) |-> $fell(bck)) else $error("word select moved off a falling edge");
  a_dout_on_fall: assert property (@(posedge link_clk) disable iff (link_srst)
    $changed(dq) |-> $fell(bck)) else $error("data moved off a falling edge");
  a_ws_slot: assert property (@(posedge link_clk) disable iff (link_srst)
    $fell(bck) |-> ws == (bit_r >= 5'h0f && bit_r != 5'h1f)) else $error("word select in wrong slot");
  a_slot_copy: assert property (@(posedge link_clk) disable iff (link_srst)
    $rose(bck) && (bit_r >= 5'h11 || bit_r == 5'h00) |-> dq == hist_r[15]) else $error("slots differ");
  a_mic_pulse: assert property (@(posedge clk) disable iff (srst)
    mic_out.valid |=> !mic_out.valid) else $error("mic valid longer than one cycle");
  a_mic_hold: assert property (@(posedge clk) disable iff (srst)
    !mic_out.valid |-> $stable(mic_out.sample)) else $error("mic sample moved without valid");
  a_spk_take: assert property (@(posedge clk) disable iff (srst)
    spk_in.valid && spk_ready |=> !spk_ready) else $error("ready stayed high after take");
  a_sleep_stop: assert property (@(posedge clk) disable iff (srst)
    (!audio_enable && sleep_allowed) [*4] |-> !bck) else $error("sleep allowed while clock runs");
endmodule
bind tis_i2s_master tis_i2s_properties #(.LINK_HZ(LINK_HZ), .BCLK_RATE_HZ(BCLK_RATE_HZ)) u_props (
  .clk, .srst, .audio_enable, .spk_in, .spk_ready, .mic_out,
  .sleep_allowed, .link_clk, .mic_serial_in, .i2s_pins);
`default_nettype wire

// file: test/tis_codec_model.sv
// Behavioural codec: clock slave, sends two words, captures speaker slots.
// Assumes pins from the master; reads them just after each edge.
`timescale 1ns/1ps
`default_nettype none
module tis_codec_model
  import tis_pkg::*;
(
  input  wire logic        bclk,
  input  wire logic        ws,
  input  wire logic        din,
  input  wire tis_sample_t left_w,
  input  wire tis_sample_t right_w,
  output var  logic        dout,
  output var  tis_sample_t got_left,
  output var  tis_sample_t got_right
);
  logic        ws_q;
  logic        ws_qq;
  tis_sample_t sh;
  tis_sample_t rx;
  initial begin
    ws_q = 1'b0;
    ws_qq = 1'b0;
    sh = '0;
    rx = '0;
    dout = 1'b0;
    got_left = '0;
    got_right = '0;
  end
  // Sample on the rise; the master drives the clock
  always @(posedge bclk) begin
    rx <= {rx[14:0], din};
  end
  // Change on the fall; ws edge closes a slot and opens the next, MSB one bit later
  always @(negedge bclk) begin
    #1;
    dout <= sh[15];
    if (ws != ws_q) begin
      sh <= ws ? right_w : left_w;
    end else begin
      sh <= sh << 1;
    end
    // A slot's LSB rides in the bit after the ws edge, so close it one fall later
    if (ws_q != ws_qq) begin
      if (ws_q) got_left <= rx;
      else got_right <= rx;
    end
    ws_q <= ws;
    ws_qq <= ws_q;
  end
endmodule
`default_nettype wire

// file: test/tis_i2s_master_test.sv
// Bench for the I2S master port with the codec model on its pins.
// Assumes a short link setting of eight link clocks per bit.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t mismatch", $time); end end
module tis_i2s_master_test;
  import tis_pkg::*;
  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        srst = 1'b1;
  logic        audio_enable = 1'b0;
  tis_spk_t    spk_in = '0;
  logic        spk_ready;
  logic        sleep_allowed;
  logic        mic_line;
  tis_mic_t    mic_out;
  tis_pins_t   pins;
  tis_sample_t left_w = '0;
  tis_sample_t right_w = '0;
  tis_sample_t got_l;
  tis_sample_t got_r;
  int          n_mismatch = 0;
  int          total_checks = 0;
  // Eight 15 ns link clocks per bit keep runs short; a frame then spans this many clk cycles
  localparam int unsigned BENCH_LINK_HZ = 8 * BCLK_HZ;
  localparam int unsigned FRAME_CYC     = FRAME_BITS * 8 * 15 / 50;
  always #25 clk = ~clk;
  always #7.5 link_clk = ~link_clk;
  tis_i2s_master #(.LINK_HZ(BENCH_LINK_HZ)) i_tis_i2s_master (
    .clk, .srst, .audio_enable, .spk_in, .spk_ready, .mic_out, .sleep_allowed,
    .link_clk, .mic_serial_in(mic_line), .i2s_pins(pins));
  tis_codec_model i_tis_codec_model (
    .bclk(pins.audio_bit_clock), .ws(pins.frame_word_select), .din(pins.spk_serial_out),
    .left_w, .right_w, .dout(mic_line), .got_left(got_l), .got_right(got_r));
  task automatic wait_mic(output int cyc);
    cyc = 0;
    do begin @(negedge clk); cyc++; end while (mic_out.valid !== 1'b1 && cyc < 400);
    if (cyc >= 400) n_mismatch++;
  endtask
  // Offer while ready, then a wrong offer while busy that must be ignored
  task automatic send(input tis_sample_t s);
    int n;
    n = 0;
    while (spk_ready !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    spk_in = {1'b1, s};
    @(negedge clk);
    `CHK(spk_ready, 1'b0)
    spk_in = {1'b1, ~s};
    @(negedge clk);
    spk_in = '0;
  endtask
  // Third pulse lies in a frame fully loaded after the changes
  task automatic t_frames();
    tis_sample_t tab [2] = '{16'ha5c3, 16'h8001};
    int c;
    audio_enable = 1'b1;
    for (int i = 0; i < 2; i++) begin
      left_w = tab[i];
      right_w = ~tab[i];
      send(tab[i] ^ 16'h0ff0);
      repeat (3) wait_mic(c);
      `CHK(mic_out.sample, tab[i])
      `CHK(got_l, tab[i] ^ 16'h0ff0)
      `CHK(got_r, tab[i] ^ 16'h0ff0)
      `CHK(c inside {FRAME_CYC, FRAME_CYC + 1}, 1'b1)
    end
  endtask
  task automatic t_stop();
    int n;
    n = 0;
    audio_enable = 1'b0;
    while (sleep_allowed !== 1'b1 && n < 200) begin @(negedge clk); n++; end
    `CHK(sleep_allowed, 1'b1)
    `CHK(pins, 3'b000)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(spk_ready, 1'b1)
    `CHK(sleep_allowed, 1'b1)
    `CHK(pins, 3'b000)
    t_frames();
    t_stop();
    close_out();
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(5000 * 50);
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
